// ==== core/scp_pkg.sv ====
// constants, addresses and types of the serial control port
package scp_pkg;
   localparam int ADDR_W = 10;
   localparam int PARAM_W = 22;
   localparam int PROG_W = 35;
   localparam int PARAM_DEPTH = 256;
   localparam int PROG_DEPTH = 512;
   localparam int SAFE_SLOTS = 5;
   localparam int RAMP_STEPS = 512;
   localparam int GAIN_W = 10;

   // address map
   localparam logic [9:0] ADR_CTRL1 = 10'h100;
   localparam logic [9:0] ADR_CTRL2 = 10'h101;
   localparam logic [9:0] ADR_VOL_L = 10'h102;
   localparam logic [9:0] ADR_VOL_R = 10'h103;
   localparam logic [9:0] ADR_VOL_S = 10'h104;
   localparam logic [9:0] ADR_CAP1 = 10'h105;
   localparam logic [9:0] ADR_CAP2 = 10'h106;
   localparam logic [9:0] ADR_CAP_LAST = 10'h108;
   localparam logic [9:0] ADR_SAFE0 = 10'h109;
   localparam logic [9:0] ADR_SAFE_LAST = 10'h10D;
   localparam logic [9:0] ADR_TEST = 10'h1FF;
   localparam logic [9:0] ADR_PROG_BASE = 10'h200;

   // data bytes per word
   localparam logic [2:0] NB_PARAM = 3'h3;
   localparam logic [2:0] NB_PROG = 3'h5;
   localparam logic [2:0] NB_CR1_W = 3'h2;
   localparam logic [2:0] NB_CR1_R = 3'h1;
   localparam logic [2:0] NB_CR2 = 3'h2;
   localparam logic [2:0] NB_VOL = 3'h3;
   localparam logic [2:0] NB_CAP_W = 3'h2;
   localparam logic [2:0] NB_CAP_R = 3'h3;
   localparam logic [2:0] NB_SAFE = 3'h4;
   localparam logic [2:0] NB_TEST = 3'h1;
   localparam logic [2:0] NB_MAX = 3'h5;

   // control word 1 fields
   localparam int CR1_AUX = 11;
   localparam int CR1_HALT = 10;
   localparam int CR1_SAFE_GO = 9;
   localparam int CR1_DCS_EN = 8;
   localparam int CR1_MUTE = 7;
   localparam int CR1_PDN = 6;
   localparam int CR1_DEEMP = 4;
   localparam int CR1_MODE = 2;
   localparam int CR1_WLEN = 0;
   localparam int ST_SAFE_DONE = 0;
   localparam int ST_SHUT = 1;
   localparam int DIR_BIT = 2;
   localparam int CAP_W = 11;

   // reset and boot values
   localparam logic [11:0] CR1_RESET = 12'h000;
   localparam logic [8:0] CR2_RESET = 9'h000;
   localparam logic [21:0] VOL_RESET = 22'h100000;
   localparam logic [7:0] TEST_RESET = 8'h00;
   localparam logic [1:0] DEEMP_441 = 2'h1;
   localparam logic [21:0] PARAM_BOOT = 22'h000000;
   localparam logic [34:0] PROG_BOOT = 35'h000000000;

   typedef enum logic [1:0] {
      PH_HDR0 = 2'b00,
      PH_HDR1 = 2'b01,
      PH_DATA = 2'b10,
      PH_SKIP = 2'b11
   } scp_phase_t;
endpackage

// ==== core/scp_ram.sv ====
// flip-flop RAM with boot fill, core read port and arbitrated write port
`timescale 1ns/1ps
module scp_ram #(
   parameter int W = 22,
   parameter int DEPTH = 256,
   parameter int AW = 8,
   parameter logic [W-1:0] BOOT_WORD = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic core_rd,
   input wire logic [AW-1:0] core_addr,
   output logic [W-1:0] core_data,
   input wire logic wr_req,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   output logic wr_ready,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data,
   output logic boot_done
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] boot_idx;

   // a core access owns the cycle; port writes wait
   assign wr_ready = boot_done && !core_rd; // RULE_12
   assign rd_data = mem[rd_addr];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_idx <= '0;
         boot_done <= 1'b0;
      end else if (!boot_done) begin
         boot_idx <= AW'(boot_idx + 1'b1);
         if (boot_idx == AW'(DEPTH - 1)) begin
            boot_done <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!boot_done) begin
         mem[boot_idx] <= BOOT_WORD; // RULE_14
      end else if (wr_req && wr_ready) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_data <= '0;
      end else if (core_rd) begin
         core_data <= mem[core_addr];
      end
   end
endmodule // scp_ram

// ==== core/scp_ramp.sv ====
// frame-stepped volume ramp for mute, halt and restart
`timescale 1ns/1ps
module scp_ramp #(
   parameter int STEPS = 512,
   parameter int GW = 10
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic frame_tick,
   input wire logic halt,
   input wire logic mute,
   output logic [GW-1:0] gain,
   output logic core_run,
   output logic shut_done
);
   logic down;

   assign down = halt || mute;

   // one step per audio frame, never a jump
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain <= GW'(STEPS);
      end else if (frame_tick) begin
         if (down && gain != '0) begin
            gain <= GW'(gain - 1'b1); // RULE_13
         end else if (!down && gain != GW'(STEPS) && core_run) begin
            gain <= GW'(gain + 1'b1); // RULE_13
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_run <= 1'b1;
         shut_done <= 1'b0;
      end else begin
         core_run <= !(halt && gain == '0); // RULE_18
         shut_done <= halt && gain == '0; // RULE_18
      end
   end
endmodule // scp_ramp

// ==== core/scp_serial_port.sv ====
// serial control port: framing, decode, registers, safeload, memories
//
// Contract
// RULE_01 - strobe low frames one transaction; high ends it
// RULE_02 - serial input is sampled on each rising serial clock edge
// RULE_03 - serial output stays undriven except during a requested read
// RULE_04 - read data is driven out from the third byte onward
// RULE_05 - direction flag 0 writes, 1 reads
// RULE_06 - byte0 zeros, flag, addr[9:8]; byte1 addr[7:0]; data MSB first
// RULE_07 - 10-bit address selects parameter RAM, program RAM or register
// RULE_08 - data byte count follows the addressed target's width
// RULE_09 - RAM burst writes store words at consecutive addresses
// RULE_10 - RAMs read and write; only control 1 and capture registers read; code returns capture data at 0x105-0x106 only, 0x107-0x108 read zero
// RULE_11 - safeload copies staged pairs into parameter RAM, core running
// RULE_12 - core accesses to parameter RAM win over port writes
// RULE_13 - shutdown and restart ramp the volume gradually
// RULE_14 - both RAMs load default contents after power-up
// RULE_15 - control 1 bits 5:4 pick de-emphasis curve or none
// RULE_16 - shelving pin selects the 44.1 kHz curve; code ignores the pin while AUX_INPUT_SEL (control 1 bit 11) is set
// RULE_17 - only written slots transfer; done bit clears on status read
// RULE_18 - halt ramps down, stops core, then reports shutdown done
// RULE_19 - a word cut short by the strobe is discarded
// RULE_20 - strobe high ignores clocks and resets bit and byte counters
`timescale 1ns/1ps
module scp_serial_port #(
   parameter int SLOTS = scp_pkg::SAFE_SLOTS,
   parameter int STEPS = scp_pkg::RAMP_STEPS
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic TRANSACTION_STROBE_N,
   input wire logic CONTROL_SERIAL_CLOCK,
   input wire logic CONTROL_SERIAL_IN,
   output logic CONTROL_SERIAL_OUT,
   output logic CONTROL_SERIAL_OUT_EN_N,
   input wire logic SHELVING_SELECT_PIN,
   input wire logic AUDIO_FRAME_TICK,
   input wire logic CORE_PARAM_RD,
   input wire logic [7:0] CORE_PARAM_ADDR,
   output logic [21:0] CORE_PARAM_DATA,
   input wire logic CORE_PROG_RD,
   input wire logic [8:0] CORE_PROG_ADDR,
   output logic [34:0] CORE_PROG_DATA,
   input wire logic [23:0] CAPTURE_DATA1,
   input wire logic [23:0] CAPTURE_DATA2,
   output logic [43:0] CAPTURE_SELECT,
   output logic CORE_RUN,
   output logic [9:0] RAMP_GAIN,
   output logic [21:0] VOLUME_LEFT,
   output logic [21:0] VOLUME_RIGHT,
   output logic [21:0] VOLUME_SUB,
   output logic [1:0] DEEMPH_CURVE,
   output logic [1:0] SERIAL_MODE,
   output logic [1:0] WORD_LENGTH,
   output logic AUX_INPUT_SEL,
   output logic CAPTURE_OUT_EN,
   output logic SOFT_POWER_DOWN,
   output logic [8:0] CONTROL_WORD2,
   output logic [7:0] TEST_WORD,
   output logic BOOT_DONE
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] word_bytes(input logic [9:0] a,
                                             input logic rd);
      if (a < scp_pkg::ADR_CTRL1) return scp_pkg::NB_PARAM;
      else if (a >= scp_pkg::ADR_PROG_BASE) return scp_pkg::NB_PROG;
      else if (a == scp_pkg::ADR_CTRL1)
         return rd ? scp_pkg::NB_CR1_R : scp_pkg::NB_CR1_W;
      else if (a == scp_pkg::ADR_CTRL2) return scp_pkg::NB_CR2;
      else if (a <= scp_pkg::ADR_VOL_S) return scp_pkg::NB_VOL;
      else if (a <= scp_pkg::ADR_CAP_LAST)
         return rd ? scp_pkg::NB_CAP_R : scp_pkg::NB_CAP_W;
      else if (a <= scp_pkg::ADR_SAFE_LAST) return scp_pkg::NB_SAFE;
      else return scp_pkg::NB_TEST;
   endfunction

   function automatic logic is_ram(input logic [9:0] a);
      return a < scp_pkg::ADR_CTRL1 || a >= scp_pkg::ADR_PROG_BASE;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic strb_s1, strb_s2, sclk_s1, sclk_s2, sclk_d, din_s1, din_s2;
   logic pin_s1, pin_s2, sclk_rise;
   scp_pkg::scp_phase_t phase;
   logic [2:0] bit_cnt, byte_cnt, nbytes;
   logic [39:0] sh, new_sh, commit_word, rd_word, aligned, obuf;
   logic [9:0] addr, commit_addr;
   logic dir, commit, load_req;
   logic [11:0] cr1;
   logic [21:0] p_rd, p_wr_data, pend_p_data;
   logic [34:0] g_rd, pend_g_data;
   logic [7:0] p_wr_addr, pend_p_addr;
   logic [8:0] pend_g_addr;
   logic p_wr_req, p_ready, p_boot, g_ready, g_boot, pend_p, pend_g;
   logic safe_go, safe_busy, safe_done, slot_hit, safe_grant, shut_done;
   logic core_run;
   logic [9:0] gain;
   logic [2:0] slot, stage_idx;
   logic [SLOTS-1:0] stage_dirty;
   logic [7:0] stage_addr [SLOTS];
   logic [21:0] stage_data [SLOTS];

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         {strb_s1, strb_s2} <= 2'h3;
         {sclk_s1, sclk_s2, sclk_d} <= 3'h0;
         {din_s1, din_s2, pin_s1, pin_s2} <= 4'h0;
      end else begin
         strb_s1 <= TRANSACTION_STROBE_N;
         strb_s2 <= strb_s1;
         sclk_s1 <= CONTROL_SERIAL_CLOCK;
         sclk_s2 <= sclk_s1;
         sclk_d <= sclk_s2;
         din_s1 <= CONTROL_SERIAL_IN;
         din_s2 <= din_s1;
         pin_s1 <= SHELVING_SELECT_PIN;
         pin_s2 <= pin_s1;
      end
   end

   assign sclk_rise = sclk_s2 && !sclk_d; // RULE_02
   assign new_sh = {sh[38:0], din_s2};

   ////////////////////////////////////////////////////////////////////////
   // framing and byte sequencing
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         phase <= scp_pkg::PH_HDR0;
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         nbytes <= 3'h0;
         sh <= 40'h0;
         dir <= 1'b0;
         addr <= 10'h000;
         commit <= 1'b0;
         commit_addr <= 10'h000;
         commit_word <= 40'h0;
         load_req <= 1'b0;
      end else begin
         commit <= 1'b0;
         load_req <= 1'b0;
         if (strb_s2) begin
            phase <= scp_pkg::PH_HDR0; // RULE_01 RULE_20
            bit_cnt <= 3'h0; // RULE_20
            byte_cnt <= 3'h0; // RULE_19
         end else if (sclk_rise) begin
            sh <= new_sh;
            bit_cnt <= 3'(bit_cnt + 3'h1);
            if (bit_cnt == 3'h7) begin
               case (phase)
                  scp_pkg::PH_HDR0: begin
                     dir <= new_sh[scp_pkg::DIR_BIT]; // RULE_05 RULE_06
                     addr[9:8] <= new_sh[1:0]; // RULE_06
                     phase <= scp_pkg::PH_HDR1;
                  end
                  scp_pkg::PH_HDR1: begin
                     addr[7:0] <= new_sh[7:0]; // RULE_06
                     nbytes <= word_bytes({addr[9:8], new_sh[7:0]}, dir); // RULE_08
                     byte_cnt <= 3'h0;
                     load_req <= dir; // RULE_04
                     phase <= scp_pkg::PH_DATA;
                  end
                  scp_pkg::PH_DATA: begin
                     if (byte_cnt == 3'(nbytes - 3'h1)) begin
                        byte_cnt <= 3'h0;
                        commit <= !dir; // RULE_05 RULE_19
                        commit_addr <= addr;
                        commit_word <= new_sh;
                        if (is_ram(addr)) begin
                           addr <= addr[9] ? {1'b1, 9'(addr[8:0] + 9'h001)}
                                           : {2'h0, 8'(addr[7:0] + 8'h01)}; // RULE_09
                           load_req <= dir; // RULE_10
                        end else begin
                           phase <= scp_pkg::PH_SKIP;
                        end
                     end else begin
                        byte_cnt <= 3'(byte_cnt + 3'h1);
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read-back path
   always_comb begin
      rd_word = 40'h0;
      if (addr < scp_pkg::ADR_CTRL1) begin
         rd_word = {18'h0, p_rd}; // RULE_07 RULE_10
      end else if (addr >= scp_pkg::ADR_PROG_BASE) begin
         rd_word = {5'h0, g_rd}; // RULE_07 RULE_10
      end else if (addr == scp_pkg::ADR_CTRL1) begin
         rd_word[scp_pkg::ST_SAFE_DONE] = safe_done;
         rd_word[scp_pkg::ST_SHUT] = shut_done; // RULE_18
      end else if (addr == scp_pkg::ADR_CAP1) begin
         rd_word = {16'h0, CAPTURE_DATA1}; // RULE_10
      end else if (addr == scp_pkg::ADR_CAP2) begin
         rd_word = {16'h0, CAPTURE_DATA2};
      end
   end

   assign aligned = rd_word << {3'(scp_pkg::NB_MAX - nbytes), 3'h0};

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CONTROL_SERIAL_OUT <= 1'b0;
         CONTROL_SERIAL_OUT_EN_N <= 1'b1;
         obuf <= 40'h0;
      end else if (strb_s2) begin
         CONTROL_SERIAL_OUT_EN_N <= 1'b1; // RULE_03
      end else if (load_req) begin
         CONTROL_SERIAL_OUT_EN_N <= 1'b0; // RULE_03 RULE_04
         CONTROL_SERIAL_OUT <= aligned[39];
         obuf <= {aligned[38:0], 1'b0};
      end else if (sclk_rise && !CONTROL_SERIAL_OUT_EN_N) begin
         CONTROL_SERIAL_OUT <= obuf[39]; // RULE_04
         obuf <= {obuf[38:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   assign safe_go = commit && commit_addr == scp_pkg::ADR_CTRL1
                    && commit_word[scp_pkg::CR1_SAFE_GO];

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cr1 <= scp_pkg::CR1_RESET;
         CONTROL_WORD2 <= scp_pkg::CR2_RESET;
         VOLUME_LEFT <= scp_pkg::VOL_RESET;
         VOLUME_RIGHT <= scp_pkg::VOL_RESET;
         VOLUME_SUB <= scp_pkg::VOL_RESET;
         CAPTURE_SELECT <= 44'h0;
         TEST_WORD <= scp_pkg::TEST_RESET;
      end else if (commit) begin
         if (commit_addr == scp_pkg::ADR_CTRL1) begin
            cr1 <= commit_word[11:0]; // RULE_15
            cr1[scp_pkg::CR1_SAFE_GO] <= 1'b0;
         end else if (commit_addr == scp_pkg::ADR_CTRL2) begin
            CONTROL_WORD2 <= commit_word[8:0];
         end else if (commit_addr == scp_pkg::ADR_VOL_L) begin
            VOLUME_LEFT <= commit_word[21:0];
         end else if (commit_addr == scp_pkg::ADR_VOL_R) begin
            VOLUME_RIGHT <= commit_word[21:0];
         end else if (commit_addr == scp_pkg::ADR_VOL_S) begin
            VOLUME_SUB <= commit_word[21:0];
         end else if (commit_addr >= scp_pkg::ADR_CAP1
                      && commit_addr <= scp_pkg::ADR_CAP_LAST) begin
            CAPTURE_SELECT[6'(commit_addr - scp_pkg::ADR_CAP1)
                           * scp_pkg::CAP_W +: scp_pkg::CAP_W]
               <= commit_word[scp_pkg::CAP_W-1:0];
         end else if (commit_addr == scp_pkg::ADR_TEST) begin
            TEST_WORD <= commit_word[7:0];
         end
      end
   end

   assign SERIAL_MODE = cr1[scp_pkg::CR1_MODE +: 2];
   assign WORD_LENGTH = cr1[scp_pkg::CR1_WLEN +: 2];
   assign AUX_INPUT_SEL = cr1[scp_pkg::CR1_AUX];
   assign CAPTURE_OUT_EN = cr1[scp_pkg::CR1_DCS_EN];
   assign SOFT_POWER_DOWN = cr1[scp_pkg::CR1_PDN];

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DEEMPH_CURVE <= 2'h0;
         BOOT_DONE <= 1'b0;
      end else begin
         DEEMPH_CURVE <= (pin_s2 && !cr1[scp_pkg::CR1_AUX])
                         ? scp_pkg::DEEMP_441 // RULE_16
                         : cr1[scp_pkg::CR1_DEEMP +: 2]; // RULE_15
         BOOT_DONE <= p_boot && g_boot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // safeload staging and transfer
   assign stage_idx = 3'(commit_addr - scp_pkg::ADR_SAFE0);

   always_comb begin
      slot_hit = 1'b0;
      slot = 3'h0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (stage_dirty[i]) begin
            slot_hit = 1'b1;
            slot = 3'(i);
         end
      end
      p_wr_req = pend_p;
      p_wr_addr = pend_p_addr;
      p_wr_data = pend_p_data;
      if (safe_busy && slot_hit) begin
         p_wr_req = 1'b1; // RULE_11
         p_wr_addr = stage_addr[slot];
         p_wr_data = stage_data[slot];
      end
   end

   assign safe_grant = safe_busy && slot_hit && p_ready; // RULE_12

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         stage_dirty <= '0;
         safe_busy <= 1'b0;
         safe_done <= 1'b0;
         for (int i = 0; i < SLOTS; i++) begin
            stage_addr[i] <= 8'h00;
            stage_data[i] <= 22'h0;
         end
      end else begin
         if (safe_grant) begin
            stage_dirty[slot] <= 1'b0; // RULE_17
         end
         if (commit && commit_addr >= scp_pkg::ADR_SAFE0
             && commit_addr <= scp_pkg::ADR_SAFE_LAST) begin
            stage_addr[stage_idx] <= commit_word[29:22];
            stage_data[stage_idx] <= commit_word[21:0];
            stage_dirty[stage_idx] <= 1'b1; // RULE_17
         end
         if (safe_go) begin
            safe_busy <= 1'b1; // RULE_11
         end else if (safe_busy && !slot_hit) begin
            safe_busy <= 1'b0;
         end
         if (load_req && addr == scp_pkg::ADR_CTRL1) begin
            safe_done <= 1'b0; // RULE_17
         end
         if (safe_busy && !slot_hit) begin
            safe_done <= 1'b1; // RULE_17
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // words waiting for a free RAM cycle
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pend_p <= 1'b0;
         pend_p_addr <= 8'h00;
         pend_p_data <= 22'h0;
         pend_g <= 1'b0;
         pend_g_addr <= 9'h000;
         pend_g_data <= 35'h0;
      end else begin
         if (pend_p && p_ready && !(safe_busy && slot_hit)) begin
            pend_p <= 1'b0; // RULE_12
         end
         if (pend_g && g_ready) begin
            pend_g <= 1'b0;
         end
         if (commit && commit_addr < scp_pkg::ADR_CTRL1) begin
            pend_p <= 1'b1; // RULE_10
            pend_p_addr <= commit_addr[7:0];
            pend_p_data <= commit_word[21:0];
         end
         if (commit && commit_addr >= scp_pkg::ADR_PROG_BASE) begin
            pend_g <= 1'b1; // RULE_10
            pend_g_addr <= commit_addr[8:0];
            pend_g_data <= commit_word[34:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   scp_ram #(.W(scp_pkg::PARAM_W), .DEPTH(scp_pkg::PARAM_DEPTH), .AW(8),
             .BOOT_WORD(scp_pkg::PARAM_BOOT)) u_param (
      .clk(SYS_CLK), .rst_n(RESET_N),
      .core_rd(CORE_PARAM_RD), .core_addr(CORE_PARAM_ADDR),
      .core_data(CORE_PARAM_DATA),
      .wr_req(p_wr_req), .wr_addr(p_wr_addr), .wr_data(p_wr_data),
      .wr_ready(p_ready), .rd_addr(addr[7:0]), .rd_data(p_rd),
      .boot_done(p_boot)
   );

   scp_ram #(.W(scp_pkg::PROG_W), .DEPTH(scp_pkg::PROG_DEPTH), .AW(9),
             .BOOT_WORD(scp_pkg::PROG_BOOT)) u_prog (
      .clk(SYS_CLK), .rst_n(RESET_N),
      .core_rd(CORE_PROG_RD), .core_addr(CORE_PROG_ADDR),
      .core_data(CORE_PROG_DATA),
      .wr_req(pend_g), .wr_addr(pend_g_addr), .wr_data(pend_g_data),
      .wr_ready(g_ready), .rd_addr(addr[8:0]), .rd_data(g_rd),
      .boot_done(g_boot)
   );

   scp_ramp #(.STEPS(STEPS), .GW(scp_pkg::GAIN_W)) u_ramp (
      .clk(SYS_CLK), .rst_n(RESET_N), .frame_tick(AUDIO_FRAME_TICK),
      .halt(cr1[scp_pkg::CR1_HALT]), .mute(cr1[scp_pkg::CR1_MUTE]),
      .gain(gain), .core_run(core_run), .shut_done(shut_done)
   );

   assign RAMP_GAIN = gain;
   assign CORE_RUN = core_run;
endmodule // scp_serial_port

// ==== verif/scp_checker.sv ====
// pin-level assertions for the serial control port
`timescale 1ns/1ps
module scp_checker (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic TRANSACTION_STROBE_N,
   input wire logic CONTROL_SERIAL_OUT_EN_N,
   input wire logic SHELVING_SELECT_PIN,
   input wire logic AUDIO_FRAME_TICK,
   input wire logic AUX_INPUT_SEL,
   input wire logic CORE_RUN,
   input wire logic [9:0] RAMP_GAIN,
   input wire logic [1:0] DEEMPH_CURVE,
   input wire logic BOOT_DONE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_idle; TRANSACTION_STROBE_N [*5]; endsequence
   sequence s_pin; (SHELVING_SELECT_PIN && !AUX_INPUT_SEL) [*5]; endsequence
   property p_idle; s_idle |-> CONTROL_SERIAL_OUT_EN_N; endproperty
   a_idle: assert property (p_idle) else $error("idle drive");
   property p_drv; $fell(CONTROL_SERIAL_OUT_EN_N) |-> !TRANSACTION_STROBE_N;
   endproperty
   a_drv: assert property (p_drv) else $error("drive off frame");
   property p_pin; s_pin |-> DEEMPH_CURVE == scp_pkg::DEEMP_441; endproperty
   a_pin: assert property (p_pin) else $error("pin curve");
   property p_step; $changed(RAMP_GAIN) |-> RAMP_GAIN == $past(RAMP_GAIN)
      + 10'h1 || RAMP_GAIN == $past(RAMP_GAIN) - 10'h1; endproperty
   a_step: assert property (p_step) else $error("gain jump");
   property p_tick; $changed(RAMP_GAIN) |-> $past(AUDIO_FRAME_TICK);
   endproperty
   a_tick: assert property (p_tick) else $error("gain off tick");
   property p_stop; !CORE_RUN |-> RAMP_GAIN == 10'h0; endproperty
   a_stop: assert property (p_stop) else $error("stopped loud");
   property p_boot; $rose(RESET_N) |-> ##[400:600] BOOT_DONE; endproperty
   a_boot: assert property (p_boot) else $error("boot late");
   property p_keep; BOOT_DONE |=> BOOT_DONE; endproperty
   a_keep: assert property (p_keep) else $error("boot lost");
endmodule // scp_checker
bind scp_serial_port scp_checker chk_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .TRANSACTION_STROBE_N(TRANSACTION_STROBE_N),
   .CONTROL_SERIAL_OUT_EN_N(CONTROL_SERIAL_OUT_EN_N),
   .SHELVING_SELECT_PIN(SHELVING_SELECT_PIN),
   .AUDIO_FRAME_TICK(AUDIO_FRAME_TICK), .AUX_INPUT_SEL(AUX_INPUT_SEL),
   .CORE_RUN(CORE_RUN), .RAMP_GAIN(RAMP_GAIN), .DEEMPH_CURVE(DEEMPH_CURVE),
   .BOOT_DONE(BOOT_DONE));

// ==== verif/scp_host.sv ====
// serial master model for the control port
`timescale 1ns/1ps
module scp_host (
   input wire logic clk,
   output logic strobe_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo,
   input wire logic sdo_en_n
);
   logic line;
   // released line never shows the last bit
   assign line = sdo_en_n ? ~sdo : sdo;
   initial begin
      strobe_n = 1'h1;
      sclk = 1'h0;
      sdi = 1'h0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic xfer(input logic rw, input logic [9:0] a, input int nd,
      input logic [47:0] wd, input int nbits, output logic [47:0] rd);
      logic [15:0] h;
      h = {5'h00, rw, a};
      rd = 48'h0;
      strobe_n = 1'h0;
      tk(4);
      for (int k = 0; k < nbits; k++) begin
         sdi = (k < 16) ? h[15 - k] : wd[8 * nd - 1 - (k - 16)];
         tk(4);
         sclk = 1'h1;
         if (k >= 16) rd = {rd[46:0], line};
         tk(4);
         sclk = 1'h0;
      end
      tk(4);
      strobe_n = 1'h1;
      tk(8);
   endtask
endmodule // scp_host

// ==== verif/tb_top.sv ====
// top-level bench for the serial control port
`timescale 1ns/1ps
module tb_top;
   logic SYS_CLK = 1'h0;
   logic RESET_N = 1'h0;
   logic pin = 1'h0;
   logic tick = 1'h0;
   logic prd = 1'h0;
   logic [7:0] padr = 8'h00;
   logic stb, sck, sdi, sdo, sdo_en_n, core_run, boot_done;
   logic [21:0] pdata, vol_l;
   logic [1:0] curve;
   logic [8:0] cw2;
   logic [7:0] tw;
   logic [47:0] r;
   int n_errors = 0;
   int checks_done = 0;
   always #10 SYS_CLK = ~SYS_CLK;
   always begin
      repeat (15) @(posedge SYS_CLK);
      #1 tick = 1'h1;
      @(posedge SYS_CLK);
      #1 tick = 1'h0;
   end
   scp_host host_u (.clk(SYS_CLK), .strobe_n(stb), .sclk(sck), .sdi(sdi),
      .sdo(sdo), .sdo_en_n(sdo_en_n));
   scp_serial_port #(.STEPS(8)) dut_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
      .TRANSACTION_STROBE_N(stb), .CONTROL_SERIAL_CLOCK(sck),
      .CONTROL_SERIAL_IN(sdi), .CONTROL_SERIAL_OUT(sdo),
      .CONTROL_SERIAL_OUT_EN_N(sdo_en_n), .SHELVING_SELECT_PIN(pin),
      .AUDIO_FRAME_TICK(tick), .CORE_PARAM_RD(prd), .CORE_PARAM_ADDR(padr),
      .CORE_PARAM_DATA(pdata), .CORE_PROG_RD(1'h0), .CORE_PROG_ADDR(9'h000),
      .CORE_PROG_DATA(), .CAPTURE_DATA1(24'hC0FFEE),
      .CAPTURE_DATA2(24'h135799), .CAPTURE_SELECT(), .CORE_RUN(core_run),
      .RAMP_GAIN(), .VOLUME_LEFT(vol_l), .VOLUME_RIGHT(), .VOLUME_SUB(),
      .DEEMPH_CURVE(curve), .SERIAL_MODE(), .WORD_LENGTH(),
      .AUX_INPUT_SEL(), .CAPTURE_OUT_EN(), .SOFT_POWER_DOWN(),
      .CONTROL_WORD2(cw2), .TEST_WORD(tw), .BOOT_DONE(boot_done));
   ////////////////////////////////////////////////////////////////////////
   task automatic tk(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic test_done();
      if (n_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input int nd, input logic [47:0] d);
      host_u.xfer(1'h0, a, nd, d, 16 + 8 * nd, r);
   endtask
   task automatic rdc(input logic [9:0] a, input int nd, input logic [47:0] e);
      host_u.xfer(1'h1, a, nd, 48'h0, 16 + 8 * nd, r);
      chk(r, e);
   endtask
   task automatic wait_on(ref logic s, input logic v);
      int i;
      for (i = 0; i < 20000 && s !== v; i++) tk(1);
      if (i == 20000) begin
         n_errors++;
         test_done();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      tk(3);
      RESET_N = 1'h1;
      wait_on(boot_done, 1'h1);
      rdc(10'h005, 3, 48'h0);
      wr(10'h005, 3, 48'h2ABCDE);
      rdc(10'h005, 3, 48'h2ABCDE);
      wr(10'h0FF, 6, 48'h0123450ABCDE);
      rdc(10'h0FF, 3, 48'h012345);
      rdc(10'h000, 3, 48'h0ABCDE);
      rdc(10'h0FF, 6, 48'h0123450ABCDE);
      host_u.xfer(1'h0, 10'h007, 3, 48'h3FFFFF, 32, r);
      rdc(10'h007, 3, 48'h0);
      wr(10'h203, 5, 48'h0712345678);
      rdc(10'h203, 5, 48'h0712345678);
      wr(scp_pkg::ADR_VOL_L, 3, 48'h054321);
      chk(vol_l, 48'h054321);
      wr(scp_pkg::ADR_CTRL2, 2, 48'h1A5);
      chk(cw2, 48'h1A5);
      wr(scp_pkg::ADR_TEST, 1, 48'hA5);
      chk(tw, 48'hA5);
      rdc(scp_pkg::ADR_VOL_L, 3, 48'h0);
      rdc(scp_pkg::ADR_CAP1, 3, 48'hC0FFEE);
      rdc(scp_pkg::ADR_CAP2, 3, 48'h135799);
      prd = 1'h1;
      padr = 8'h05;
      tk(1);
      prd = 1'h0;
      chk(pdata, 48'h2ABCDE);
      for (int v = 0; v < 4; v++) begin
         wr(scp_pkg::ADR_CTRL1, 2, 48'(v << 4));
         chk(curve, 48'(v));
      end
      pin = 1'h1;
      tk(5);
      chk(curve, 48'h1);
      pin = 1'h0;
      wr(scp_pkg::ADR_SAFE0, 4, 48'h02555555);
      wr(scp_pkg::ADR_CTRL1, 2, 48'h200);
      rdc(10'h009, 3, 48'h155555);
      rdc(scp_pkg::ADR_CTRL1, 1, 48'h1);
      rdc(scp_pkg::ADR_CTRL1, 1, 48'h0);
      wr(scp_pkg::ADR_CTRL1, 2, 48'h400);
      wait_on(core_run, 1'h0);
      tk(2);
      rdc(scp_pkg::ADR_CTRL1, 1, 48'h2);
      wr(scp_pkg::ADR_CTRL1, 2, 48'h000);
      chk(core_run, 48'h1);
      wr(10'h009, 3, 48'h000111);
      wr(scp_pkg::ADR_CTRL1, 2, 48'h200);
      rdc(10'h009, 3, 48'h000111);
      test_done();
   end
endmodule // tb_top
